// [hdl/xsd_core.sv]
// execute logic for the eight extended instructions
// assumes one instruction word per cycle, the core holds its pipeline while busy is high
`default_nettype none
module xsd_core
  import xsd_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  input  wire logic                    extension_enable_config_bit,
  input  wire logic                    instr_valid,
  input  wire logic [15:0]             instr,
  input  wire logic [PC_W-1:0]         pc_next,
  input  wire logic [PC_W-1:0]         return_stack_top,
  input  wire logic [7:0]              working_register,
  input  wire logic [7:0]              counter_high_latch,
  input  wire logic [4:0]              counter_upper_latch,
  input  wire logic                    byte_op,
  input  wire logic                    byte_access_bank,
  input  wire logic [7:0]              byte_file_addr,
  output logic                         ext_hit,
  output logic                         busy,
  output logic [PTR_W-1:0]             pointer0,
  output logic [PTR_W-1:0]             pointer1,
  output logic [PTR_W-1:0]             pointer_two,
  output logic                         pc_load,
  output logic [PC_W-1:0]              pc_value,
  output logic                         push_stack,
  output logic [PC_W-1:0]              push_value,
  output logic                         mem_rd,
  output logic [PTR_W-1:0]             mem_rd_addr,
  output logic                         mem_wr,
  output logic [PTR_W-1:0]             mem_wr_addr,
  output logic [7:0]                   mem_wr_data,
  input  wire logic [7:0]              mem_rd_data,
  output logic                         idx_active,
  output logic [PTR_W-1:0]             idx_addr
);
  xsd_op_t                op;
  xsd_state_t             state_ff, nxt_state;
  logic [PTR_W-1:0]       ptr_ff [3];
  logic [PTR_W-1:0]       nxt_ptr [3];
  logic [PTR_W-1:0]       src_ff, nxt_src;
  logic                   dst_idx_ff, nxt_dst_idx;
  logic [6:0]             soff_ff, nxt_soff;
  logic [PTR_W-1:0]       lit6;
  logic [1:0]             sel;
  logic                   second_ok;

  xsd_decode u_dec (
    .instr  (instr),
    .enable (extension_enable_config_bit),
    .op     (op)
  );

  assign lit6      = {6'h00, instr[5:0]};
  assign sel       = instr[7:6];
  assign second_ok = instr[15:12] == SECOND_PFX;
  assign busy      = state_ff != XSD_IDLE;
  assign ext_hit   = instr_valid && state_ff == XSD_IDLE && op != XSD_NONE;
  assign pointer0    = ptr_ff[0];
  assign pointer1    = ptr_ff[1];
  assign pointer_two = ptr_ff[2];
  // index mode uses the registered pointer, so an update this cycle is not seen: byte ops never coincide with ext ops
  assign idx_active = extension_enable_config_bit && byte_op && !byte_access_bank
                      && byte_file_addr <= IDX_MAX;
  assign idx_addr   = ptr_ff[2] + {4'h0, byte_file_addr};

  always_comb begin
    for (int i = 0; i < 3; i++) nxt_ptr[i] = ptr_ff[i];
    nxt_state   = state_ff;
    nxt_src     = src_ff;
    nxt_dst_idx = dst_idx_ff;
    nxt_soff    = soff_ff;
    pc_load     = 1'b0;
    pc_value    = return_stack_top;
    push_stack  = 1'b0;
    push_value  = pc_next;
    mem_rd      = 1'b0;
    mem_rd_addr = src_ff;
    mem_wr      = 1'b0;
    mem_wr_addr = ptr_ff[2];
    mem_wr_data = instr[7:0];
    unique case (state_ff)
      XSD_IDLE: begin
        if (ext_hit) begin
          unique case (op)
            XSD_ADD:  nxt_ptr[sel] = ptr_ff[sel] + lit6;
            XSD_SUB:  nxt_ptr[sel] = ptr_ff[sel] - lit6;
            XSD_ADDR: begin
              nxt_ptr[2] = ptr_ff[2] + lit6;
              pc_load    = 1'b1;
              nxt_state  = XSD_RET2;
            end
            XSD_SUBR: begin
              nxt_ptr[2] = ptr_ff[2] - lit6;
              pc_load    = 1'b1;
              nxt_state  = XSD_RET2;
            end
            XSD_WCALL: begin
              push_stack = 1'b1;
              pc_load    = 1'b1;
              pc_value   = {counter_upper_latch, counter_high_latch, working_register};
              nxt_state  = XSD_RET2;
            end
            XSD_PUSH: begin
              mem_wr     = 1'b1;
              nxt_ptr[2] = ptr_ff[2] - 12'h001;
            end
            default: begin
              nxt_src   = ptr_ff[2] + {5'h00, instr[6:0]};
              nxt_soff  = instr[6:0];
              nxt_dst_idx = op == XSD_MOVE_IDX;
              nxt_state = XSD_MOVE2;
            end
          endcase
        end
      end
      XSD_RET2: nxt_state = XSD_IDLE;
      XSD_MOVE2: begin
        // second word not carrying the f prefix is dropped rather than executed as garbage
        if (instr_valid) begin
          nxt_state = XSD_IDLE;
          if (second_ok) begin
            mem_rd      = 1'b1;
            mem_wr      = 1'b1;
            mem_wr_data = mem_rd_data;
            mem_wr_addr = dst_idx_ff ? ptr_ff[2] + {5'h00, instr[6:0]} : instr[11:0];
          end
        end
      end
      default: nxt_state = XSD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < 3; i++) ptr_ff[i] <= PTR_RST;
      state_ff <= XSD_IDLE;
      src_ff   <= PTR_RST;
      dst_idx_ff <= 1'b0;
      soff_ff  <= 7'h00;
    end else begin
      for (int i = 0; i < 3; i++) ptr_ff[i] <= nxt_ptr[i];
      state_ff <= nxt_state;
      src_ff   <= nxt_src;
      dst_idx_ff <= nxt_dst_idx;
      soff_ff  <= nxt_soff;
    end
  end

  // enable and reset
  chk_off_no_hit: assert property (@(posedge clk_sys) disable iff (srst)
    !extension_enable_config_bit |-> !ext_hit && !idx_active)
    else $error("ext active while disabled");
  chk_rst_state: assert property (@(posedge clk_sys)
    srst |=> state_ff == XSD_IDLE && ptr_ff[0] == PTR_RST && ptr_ff[1] == PTR_RST && ptr_ff[2] == PTR_RST)
    else $error("reset state wrong");

  // one-cycle forms: arithmetic wraps at 12 bits, there is no status path to disturb
  chk_add_one: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_ADD && sel == 2'h0 |=>
      ptr_ff[0] == $past(ptr_ff[0]) + $past(lit6) && state_ff == XSD_IDLE)
    else $error("pointer add wrong");
  chk_sub_ptr: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_SUB && sel == 2'h1 |=> ptr_ff[1] == $past(ptr_ff[1]) - $past(lit6))
    else $error("pointer subtract wrong");
  chk_one_cycle: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && (op == XSD_ADD || op == XSD_SUB || op == XSD_PUSH) |=> !busy)
    else $error("one cycle form stalled");

  // return forms: pointer update and counter load share the first cycle, the second is idle
  chk_addr_two: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_ADDR |-> pc_load ##1 busy ##1 !busy)
    else $error("add return not two cycles");
  chk_addr_ptr: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_ADDR |=> ptr_ff[2] == $past(ptr_ff[2]) + $past(lit6))
    else $error("add return pointer wrong");
  chk_subr_ret: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_SUBR |-> pc_load && pc_value == return_stack_top ##1 !pc_load)
    else $error("subtract return wrong");
  chk_subr_ptr: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_SUBR |=> ptr_ff[2] == $past(ptr_ff[2]) - $past(lit6))
    else $error("subtract return pointer wrong");
  chk_ret_idle: assert property (@(posedge clk_sys) disable iff (srst)
    state_ff == XSD_RET2 |-> !ext_hit && !pc_load && !push_stack && !mem_wr && !mem_rd)
    else $error("second cycle not idle");
  chk_busy_hold: assert property (@(posedge clk_sys) disable iff (srst)
    busy |=> ptr_ff[0] == $past(ptr_ff[0]) && ptr_ff[1] == $past(ptr_ff[1]) && ptr_ff[2] == $past(ptr_ff[2]))
    else $error("pointer moved while busy");

  // call through the working register
  chk_wcall_two: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_WCALL |-> pc_load ##1 busy ##1 !busy)
    else $error("call not two cycles");
  chk_wcall_tgt: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_WCALL |-> push_stack && pc_value[7:0] == working_register
      && pc_value[15:8] == counter_high_latch && pc_value[20:16] == counter_upper_latch)
    else $error("call target wrong");
  chk_wcall_ret: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_WCALL |-> push_value == pc_next)
    else $error("call return address wrong");

  // literal push onto the software stack
  chk_push_dec: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_PUSH |-> mem_wr && mem_wr_addr == ptr_ff[2]
      ##1 ptr_ff[2] == $past(ptr_ff[2]) - 12'h001)
    else $error("push literal wrong");
  chk_push_data: assert property (@(posedge clk_sys) disable iff (srst)
    ext_hit && op == XSD_PUSH |-> mem_wr_data == instr[7:0])
    else $error("push data wrong");

  // two-word moves: read and write both happen in the second-word cycle
  chk_move_src: assert property (@(posedge clk_sys) disable iff (srst)
    state_ff == XSD_MOVE2 && instr_valid && second_ok |->
      mem_rd && mem_rd_addr == ptr_ff[2] + {5'h00, soff_ff})
    else $error("move source wrong");
  chk_move_dst: assert property (@(posedge clk_sys) disable iff (srst)
    state_ff == XSD_MOVE2 && !dst_idx_ff && instr_valid && second_ok |->
      mem_wr && mem_wr_addr == instr[11:0] && mem_wr_data == mem_rd_data)
    else $error("move destination wrong");
  chk_move_idx: assert property (@(posedge clk_sys) disable iff (srst)
    state_ff == XSD_MOVE2 && dst_idx_ff && instr_valid && second_ok |->
      mem_wr && mem_wr_addr == ptr_ff[2] + {5'h00, instr[6:0]} && mem_wr_data == mem_rd_data)
    else $error("indexed destination wrong");
  chk_move_drop: assert property (@(posedge clk_sys) disable iff (srst)
    state_ff == XSD_MOVE2 && instr_valid && !second_ok |-> !mem_wr && !mem_rd ##1 !busy)
    else $error("bad second word not dropped");

  // indexed offset mode for byte instructions
  chk_idx_addr: assert property (@(posedge clk_sys) disable iff (srst)
    idx_active |-> byte_file_addr <= IDX_MAX && idx_addr == ptr_ff[2] + {4'h0, byte_file_addr})
    else $error("indexed offset wrong");
  chk_idx_off: assert property (@(posedge clk_sys) disable iff (srst)
    byte_op && (byte_access_bank || byte_file_addr > IDX_MAX) |-> !idx_active)
    else $error("indexed offset outside range");

  cov_addr: cover property (@(posedge clk_sys) ext_hit && op == XSD_ADDR);
  cov_subr: cover property (@(posedge clk_sys) ext_hit && op == XSD_SUBR);
  cov_wcall: cover property (@(posedge clk_sys) ext_hit && op == XSD_WCALL);
  cov_move_idx: cover property (@(posedge clk_sys) state_ff == XSD_MOVE2 && dst_idx_ff && instr_valid);
  cov_push: cover property (@(posedge clk_sys) ext_hit && op == XSD_PUSH);
endmodule : xsd_core
`default_nettype wire

// [hdl/xsd_decode.sv]
// pure opcode classifier for the extension
// gates the result with the enable input itself, so op is XSD_NONE while enable is low
`default_nettype none
module xsd_decode
  import xsd_pkg::*;
(
  input  wire logic [15:0]     instr,
  input  wire logic            enable,
  output var xsd_pkg::xsd_op_t op
);
  always_comb begin
    op = XSD_NONE;
    if (enable) begin
      if (instr == OP_WCALL) begin
        op = XSD_WCALL;
      end else begin
        unique case (instr[15:8])
          OP_ADD:  op = (instr[7:6] == SEL_RET) ? XSD_ADDR : XSD_ADD;
          OP_SUB:  op = (instr[7:6] == SEL_RET) ? XSD_SUBR : XSD_SUB;
          OP_PUSH: op = XSD_PUSH;
          OP_MOVS: op = instr[7] ? XSD_MOVE_IDX : XSD_MOVE_ABS;
          default: op = XSD_NONE;
        endcase
      end
    end
  end
endmodule : xsd_decode
`default_nettype wire

// [hdl/xsd_pkg.sv]
// constants and types for the extended stack instruction decoder
// assumes a core that presents one instruction word per cycle with a valid strobe
// Contract
// - all extended instructions and indexed offset mode stay off after reset and work only while the enable bit is set.
//   the core still executes the second word of a move when the enable bit drops after the first word.
// - exactly eight extra instructions are added, all but the working register call using the pointers.
// - opcode e8 with select 0..2 adds the 6-bit literal to that pointer in one cycle without flags.
// - opcode e8 with select 3 adds the literal to pointer two then returns, taking two cycles.
// - opcode e9 with select 0..2 subtracts the literal from that pointer in one cycle without flags.
// - opcode e9 with select 3 subtracts from pointer two then returns, two cycles, no flags.
// - word 0014 is a two-cycle call whose target low byte is the working register, no flags.
// - opcode ea stores the 8-bit literal at pointer two and decrements pointer two in one cycle.
// - opcode eb with bit 7 clear plus an f-prefixed word moves from pointer two plus offset to a 12-bit address in two cycles.
// - opcode eb with bit 7 set plus an f-prefixed word moves between two pointer-two-relative addresses.
// - the add or subtract and return forms load the counter from the return stack top and idle in the second cycle.
// - the working register call pushes the next address, then loads low byte from working register and high bytes from latches.
// - with the extension on, a byte instruction with access flag clear and address at most 5f is offset from pointer two.
`default_nettype none
package xsd_pkg;
  localparam int          PTR_W      = 12;
  localparam int          PC_W       = 21;
  localparam int          NUM_EXT    = 8;
  localparam logic [7:0]  OP_ADD     = 8'he8;
  localparam logic [7:0]  OP_SUB     = 8'he9;
  localparam logic [7:0]  OP_PUSH    = 8'hea;
  localparam logic [7:0]  OP_MOVS    = 8'heb;
  localparam logic [15:0] OP_WCALL   = 16'h0014;
  localparam logic [3:0]  SECOND_PFX = 4'hf;
  localparam logic [1:0]  SEL_RET    = 2'h3;
  localparam logic [7:0]  IDX_MAX    = 8'h5f;
  localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
  typedef enum logic [3:0] {
    XSD_NONE  = 4'h0,
    XSD_ADD   = 4'h1,
    XSD_ADDR  = 4'h2,
    XSD_SUB   = 4'h3,
    XSD_SUBR  = 4'h4,
    XSD_WCALL    = 4'h5,
    XSD_PUSH     = 4'h6,
    XSD_MOVE_ABS = 4'h7,
    XSD_MOVE_IDX = 4'h8
  } xsd_op_t;
  typedef enum logic [1:0] {
    XSD_IDLE  = 2'h0,
    XSD_RET2  = 2'h1,
    XSD_MOVE2 = 2'h2
  } xsd_state_t;
endpackage : xsd_pkg
`default_nettype wire

// [verif/tb_extended_stack_instruction_decode.sv]
// self-checking bench for the extended stack instruction execute block
// assumes xsd_pkg and xsd_core compiled first; one 40 MHz clock, bench drives every port
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_extended_stack_instruction_decode
  import xsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, srst = 1, en = 0, instr_valid = 0, byte_op = 0, byte_access_bank = 0;
  logic [15:0] instr = 16'h0000;
  logic [PC_W-1:0] pc_next = 21'h000102, stack_top = 21'h012345;
  logic [7:0] work_reg = 8'h06, hlat = 8'h10, fa = 8'h00, rd_data = 8'h33;
  logic [4:0] ulat = 5'h00;
  logic ext_hit, busy, pc_load, push_stack, mem_rd, mem_wr, idx_active;
  logic [PTR_W-1:0] p0, p1, p2, rd_addr, wr_addr, idx_addr;
  logic [PC_W-1:0] pc_value, push_value;
  logic [7:0] wr_data;
  int err_count = 0, n_tests = 0, cyc = 0;
  xsd_core u_xsd_core (.clk_sys(clk_sys), .srst(srst), .extension_enable_config_bit(en),
    .instr_valid(instr_valid), .instr(instr), .pc_next(pc_next), .return_stack_top(stack_top),
    .working_register(work_reg), .counter_high_latch(hlat), .counter_upper_latch(ulat),
    .byte_op(byte_op), .byte_access_bank(byte_access_bank), .byte_file_addr(fa),
    .ext_hit(ext_hit), .busy(busy), .pointer0(p0), .pointer1(p1), .pointer_two(p2),
    .pc_load(pc_load), .pc_value(pc_value), .push_stack(push_stack), .push_value(push_value),
    .mem_rd(mem_rd), .mem_rd_addr(rd_addr), .mem_wr(mem_wr), .mem_wr_addr(wr_addr),
    .mem_wr_data(wr_data), .mem_rd_data(rd_data), .idx_active(idx_active), .idx_addr(idx_addr));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // hang guard: whole run is well under a hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic issue(input logic [15:0] w);
    @(posedge clk_sys);
    #2;
    instr = w;
    instr_valid = 1;
    #1;
  endtask : issue
  task automatic idle_cyc();
    @(posedge clk_sys);
    #2;
    instr_valid = 0;
    #1;
  endtask : idle_cyc
  task automatic t_disabled();
    issue(16'he885);
    `CHK("hit_off", 1'b0, ext_hit)
    byte_op = 1;
    fa = 8'h10;
    idle_cyc();
    `CHK("idx_off", 1'b0, idx_active)
    `CHK("p2_off", 12'h000, p2)
    byte_op = 0;
    en = 1;
  endtask : t_disabled
  task automatic t_add_sub();
    issue(16'he83f);
    `CHK("add_hit", 1'b1, ext_hit)
    issue(16'he841);
    issue(16'he8bf);
    issue(16'he942);
    idle_cyc();
    `CHK("p0_add", 12'h03f, p0)
    `CHK("p2_add", 12'h03f, p2)
    `CHK("p1_wrap", 12'hfff, p1)
    `CHK("no_busy", 1'b0, busy)
  endtask : t_add_sub
  task automatic t_push_index();
    issue(16'heaa5);
    `CHK("push_wr", 1'b1, mem_wr)
    `CHK("push_addr", 12'h03f, wr_addr)
    `CHK("push_data", 8'ha5, wr_data)
    byte_op = 1;
    fa = 8'h5f;
    idle_cyc();
    `CHK("push_dec", 12'h03e, p2)
    `CHK("idx_on", 1'b1, idx_active)
    `CHK("idx_addr", 12'h09d, idx_addr)
    fa = 8'h60;
    #1;
    `CHK("idx_above", 1'b0, idx_active)
    fa = 8'h5f;
    byte_access_bank = 1;
    #1;
    `CHK("idx_bank", 1'b0, idx_active)
    byte_op = 0;
    byte_access_bank = 0;
  endtask : t_push_index
  task automatic t_return(input logic [15:0] w, input logic [PTR_W-1:0] exp_p2);
    issue(w);
    `CHK("ret_load", 1'b1, pc_load)
    `CHK("ret_pc", stack_top, pc_value)
    issue(16'he841);
    `CHK("ret_busy", 1'b1, busy)
    `CHK("ret_nop", 1'b0, ext_hit)
    idle_cyc();
    `CHK("ret_p2", exp_p2, p2)
    `CHK("ret_p1", 12'hfff, p1)
    `CHK("ret_done", 1'b0, busy)
  endtask : t_return
  task automatic t_call_via_working_register();
    issue(16'h0014);
    `CHK("call_push", 1'b1, push_stack)
    `CHK("call_ret", pc_next, push_value)
    `CHK("call_pc", 21'h001006, pc_value)
    idle_cyc();
    `CHK("call_busy", 1'b1, busy)
    idle_cyc();
    `CHK("call_done", 1'b0, busy)
  endtask : t_call_via_working_register
  task automatic t_move(input logic [15:0] w1, input logic [15:0] w2, input logic [PTR_W-1:0] dst);
    issue(w1);
    `CHK("mv_hit", 1'b1, ext_hit)
    issue(w2);
    `CHK("mv_busy", 1'b1, busy)
    `CHK("mv_rd", 1'b1, mem_rd)
    `CHK("mv_src", 12'h045, rd_addr)
    `CHK("mv_wr", 1'b1, mem_wr)
    `CHK("mv_dst", dst, wr_addr)
    `CHK("mv_data", 8'h33, wr_data)
    idle_cyc();
    `CHK("mv_done", 1'b0, busy)
  endtask : t_move
  task automatic t_move_drop();
    issue(16'heb05);
    issue(16'he123);
    `CHK("drop_busy", 1'b1, busy)
    `CHK("drop_wr", 1'b0, mem_wr)
    `CHK("drop_rd", 1'b0, mem_rd)
    idle_cyc();
    `CHK("drop_done", 1'b0, busy)
  endtask : t_move_drop
  task automatic t_reset_mid();
    issue(16'heb05);
    `CHK("mid_hit", 1'b1, ext_hit)
    @(posedge clk_sys);
    #2;
    instr_valid = 0;
    srst = 1;
    #1;
    `CHK("mid_busy", 1'b1, busy)
    repeat (2) @(posedge clk_sys);
    #2;
    srst = 0;
    #1;
    `CHK("mid_idle", 1'b0, busy)
    `CHK("mid_p1", 12'h000, p1)
    `CHK("mid_p2", 12'h000, p2)
    issue(16'he801);
    idle_cyc();
    `CHK("mid_add", 12'h001, p0)
  endtask : t_reset_mid
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge clk_sys);
    #2;
    srst = 0;
    #1;
    `CHK("rst_p0", 12'h000, p0)
    `CHK("rst_busy", 1'b0, busy)
    t_disabled();
    t_add_sub();
    t_push_index();
    t_return(16'he8c3, 12'h041);
    t_return(16'he9c1, 12'h040);
    t_call_via_working_register();
    t_move(16'heb05, 16'hf123, 12'h123);
    t_move(16'heb85, 16'hf00a, 12'h04a);
    t_move_drop();
    t_reset_mid();
    complete_run();
  end
endmodule : tb_extended_stack_instruction_decode
`default_nettype wire
